// [shared/spi_master_regs.svh]
// Behaviour
// - Master operation only while master enable set
// - Data write while not busy loads transmit buffer, not shifter
// - Empty shifter takes buffered byte, transfer starts
// - Shift out on mosi at once, drive sck
// - Set done flag at end, request interrupt
// - Slave shifts miso meanwhile; one flag for both
// - Capture miso byte most significant bit first
// - Full byte goes to receive buffer for reads
// - Default select mode multi-master, pin is input
// - Low select in multi-master: disable, flag fault
// - Mode fault requests interrupt when enabled
// - After fault stay disabled until software re-enables
// - Select mode 00: three-wire, select pin ignored
// - High select bit: pin drives low select bit
// - Write during transfer sets collision flag, interrupt
// - Buffer empty drops on write while not busy, rises on move
`ifndef SPI_MASTER_REGS_SVH
`define SPI_MASTER_REGS_SVH

`define DATA_W          8
`define SEL_MODE_MULTI  2'h1
`define SEL_MODE_3WIRE  2'h0
`define SEL_HI_BIT      1
`define SEL_LO_BIT      0
`define RST_SEL_MODE    2'h1
`define RST_TX_EMPTY    1'h1
`define LAST_BIT_IDX    3'h7
`define SCK_HALF_CYCLES 2

`endif

// [shared/spi_master_pkg.sv]
package spi_master_pkg;
  `include "spi_master_regs.svh"

  typedef struct packed {
    logic       master_enable_flag;
    logic       interface_enable_bit;
    logic [1:0] select_mode_field;
  } ctrl_s;

  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
  } flags_s;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'h0,
    LINK_SETUP = 2'h1,
    LINK_HIGH  = 2'h2
  } link_state_e;
endpackage

// [logic/spi_shift_engine.sv]
`timescale 1ns/1ps
module spi_shift_engine
  import spi_master_pkg::*;
#(
  parameter int HALF_CYCLES = `SCK_HALF_CYCLES
) (
  input  wire logic                link_clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                start_tog_in,
  input  wire logic                abort_in,
  input  wire logic [`DATA_W-1:0] tx_byte_in,
  input  wire logic                miso_in,
  output logic                     done_tog_out,
  output logic      [`DATA_W-1:0] rx_byte_out,
  output logic                     sck_out,
  output logic                     mosi_out
);
  localparam int HW = $clog2(HALF_CYCLES + 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYCLES - 1);

  logic [2:0]         start_sync;
  logic [1:0]         abort_sync;
  logic [1:0]         miso_sync;
  link_state_e        state;
  logic [`DATA_W-1:0] tx_sh;
  logic [2:0]         bit_cnt;
  logic [HW-1:0]      half_cnt;
  logic               start_evt;

  // Crossings from the system domain and the pin
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      start_sync <= 3'h0;
      abort_sync <= 2'h3;
      miso_sync  <= 2'h0;
    end else begin
      start_sync <= {start_sync[1:0], start_tog_in};
      abort_sync <= {abort_sync[0], abort_in};
      miso_sync  <= {miso_sync[0], miso_in};
    end
  end

  assign start_evt = start_sync[2] ^ start_sync[1];

  // Bit sequencer, mode 0 timing
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state        <= LINK_IDLE;
      tx_sh        <= 8'h00;
      rx_byte_out  <= 8'h00;
      bit_cnt      <= 3'h0;
      half_cnt     <= '0;
      sck_out      <= 1'h0;
      mosi_out     <= 1'h0;
      done_tog_out <= 1'h0;
    end else begin
      case (state)
        LINK_IDLE: begin
          sck_out <= 1'h0;
          if (start_evt && abort_sync[1]) begin
            done_tog_out <= ~done_tog_out;
          end else if (start_evt) begin
            tx_sh    <= tx_byte_in;
            mosi_out <= tx_byte_in[`DATA_W-1];
            bit_cnt  <= 3'h0;
            half_cnt <= '0;
            state    <= LINK_SETUP;
          end
        end
        LINK_SETUP: begin
          if (abort_sync[1]) begin
            done_tog_out <= ~done_tog_out;
            state        <= LINK_IDLE;
          end else if (half_cnt == HALF_LAST) begin
            half_cnt <= '0;
            sck_out  <= 1'h1;
            state    <= LINK_HIGH;
          end else begin
            half_cnt <= half_cnt + HW'(1);
          end
        end
        LINK_HIGH: begin
          if (abort_sync[1]) begin
            sck_out      <= 1'h0;
            done_tog_out <= ~done_tog_out;
            state        <= LINK_IDLE;
          end else if (half_cnt == HALF_LAST) begin
            half_cnt    <= '0;
            sck_out     <= 1'h0;
            rx_byte_out <= {rx_byte_out[`DATA_W-2:0], miso_sync[1]};
            tx_sh       <= {tx_sh[`DATA_W-2:0], 1'h0};
            mosi_out    <= tx_sh[`DATA_W-2];
            bit_cnt     <= bit_cnt + 3'h1;
            if (bit_cnt == `LAST_BIT_IDX) begin
              done_tog_out <= ~done_tog_out;
              state        <= LINK_IDLE;
            end else begin
              state <= LINK_SETUP;
            end
          end else begin
            half_cnt <= half_cnt + HW'(1);
          end
        end
        default: begin
          state <= LINK_IDLE;
        end
      endcase
    end
  end
endmodule

// [logic/spi_master_ctrl.sv]
`timescale 1ns/1ps
module spi_master_ctrl
  import spi_master_pkg::*;
#(
  parameter int HALF_CYCLES = `SCK_HALF_CYCLES
) (
  input  wire logic                ref_clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                link_clk_in,
  input  wire logic                ctrl_wr_in,
  input  wire ctrl_s               ctrl_in,
  input  wire flags_s              flag_clr_in,
  input  wire logic                data_wr_in,
  input  wire logic [`DATA_W-1:0] data_in,
  input  wire logic                int_enable_in,
  input  wire logic                miso_in,
  input  wire logic                nss_in,
  output logic                     sck_out,
  output logic                     mosi_out,
  output logic                     nss_out,
  output logic                     nss_oe_n_out,
  output ctrl_s                    ctrl_out,
  output flags_s                   flags_out,
  output logic                     tx_buffer_empty_status_out,
  output logic                     busy_out,
  output logic      [`DATA_W-1:0] rx_data_out,
  output logic                     irq_out
);
  logic [1:0]         nss_sync;
  logic [2:0]         done_sync;
  logic [`DATA_W-1:0] tx_buf;
  logic [`DATA_W-1:0] shift_load;
  logic               start_tog;
  logic               abort_lvl;
  logic               done_tog;
  logic [`DATA_W-1:0] rx_shift;
  logic               active;
  logic               fault_evt;
  logic               start_ok;
  logic               done_evt;
  logic               collide_evt;

  // Select pin crossing
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nss_sync <= 2'h3;
    end else begin
      nss_sync <= {nss_sync[0], nss_in};
    end
  end

  // Completion crossing from the link domain
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      done_sync <= 3'h0;
    end else begin
      done_sync <= {done_sync[1:0], done_tog};
    end
  end

  assign active    = ctrl_out.master_enable_flag
                   & ctrl_out.interface_enable_bit;
  assign fault_evt = ctrl_out.master_enable_flag
                   & (ctrl_out.select_mode_field == `SEL_MODE_MULTI)
                   & ~nss_sync[1];
  assign start_ok    = ~tx_buffer_empty_status_out & ~busy_out & active;
  assign done_evt    = (done_sync[2] ^ done_sync[1]) & active;
  assign collide_evt = data_wr_in & busy_out;

  // Control bits; a fault overrides software
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_out.master_enable_flag   <= 1'h0;
      ctrl_out.interface_enable_bit <= 1'h0;
      ctrl_out.select_mode_field    <= `RST_SEL_MODE;
    end else begin
      if (ctrl_wr_in) begin
        ctrl_out <= ctrl_in;
      end
      if (fault_evt) begin
        ctrl_out.master_enable_flag   <= 1'h0;
        ctrl_out.interface_enable_bit <= 1'h0;
      end
    end
  end

  // Transmit buffer and empty status
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_buf                     <= 8'h00;
      tx_buffer_empty_status_out <= `RST_TX_EMPTY;
    end else begin
      if (data_wr_in && !busy_out) begin
        tx_buf                     <= data_in;
        tx_buffer_empty_status_out <= 1'h0;
      end else if (start_ok) begin
        tx_buffer_empty_status_out <= 1'h1;
      end
    end
  end

  // Hand a byte to the shifter
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_load <= 8'h00;
      start_tog  <= 1'h0;
      busy_out   <= 1'h0;
    end else begin
      if (start_ok) begin
        shift_load <= tx_buf;
        start_tog  <= ~start_tog;
        busy_out   <= 1'h1;
      end else if (done_sync[2] ^ done_sync[1]) begin
        busy_out <= 1'h0;
      end
    end
  end

  // Stops the shifter when disabled
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      abort_lvl <= 1'h1;
    end else begin
      abort_lvl <= ~active;
    end
  end

  // Receive buffer
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_data_out <= 8'h00;
    end else if (done_evt) begin
      rx_data_out <= rx_shift;
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_out <= 3'h0;
    end else begin
      if (done_evt) begin
        flags_out.transfer_done_flag <= 1'h1;
      end else if (flag_clr_in.transfer_done_flag) begin
        flags_out.transfer_done_flag <= 1'h0;
      end
      if (collide_evt) begin
        flags_out.write_collision_flag <= 1'h1;
      end else if (flag_clr_in.write_collision_flag) begin
        flags_out.write_collision_flag <= 1'h0;
      end
      if (fault_evt) begin
        flags_out.mode_fault_flag <= 1'h1;
      end else if (flag_clr_in.mode_fault_flag) begin
        flags_out.mode_fault_flag <= 1'h0;
      end
    end
  end

  // Interrupt request
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'h0;
    end else begin
      irq_out <= int_enable_in & (|flags_out);
    end
  end

  // Select pin drive
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nss_out      <= 1'h1;
      nss_oe_n_out <= 1'h1;
    end else if (ctrl_out.select_mode_field[`SEL_HI_BIT]) begin
      nss_out      <= ctrl_out.select_mode_field[`SEL_LO_BIT];
      nss_oe_n_out <= 1'h0;
    end else begin
      nss_out      <= 1'h1;
      nss_oe_n_out <= 1'h1;
    end
  end

  spi_shift_engine #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_engine (
    .link_clk_in  (link_clk_in),
    .sys_rst_in   (sys_rst_in),
    .start_tog_in (start_tog),
    .abort_in     (abort_lvl),
    .tx_byte_in   (shift_load),
    .miso_in      (miso_in),
    .done_tog_out (done_tog),
    .rx_byte_out  (rx_shift),
    .sck_out      (sck_out),
    .mosi_out     (mosi_out)
  );
endmodule

// [dv/spi_master_ctrl_props.sv]
`timescale 1ns/1ps
module spi_master_ctrl_props
  import spi_master_pkg::*;
#(
  parameter int HALF_CYCLES = 2
) (
  input wire logic   ref_clk_in,
  input wire logic   sys_rst_in,
  input wire flags_s flag_clr_in,
  input wire logic   data_wr_in,
  input wire logic   int_enable_in,
  input wire logic   nss_in,
  input wire logic   nss_out,
  input wire logic   nss_oe_n_out,
  input wire ctrl_s  ctrl_out,
  input wire flags_s flags_out,
  input wire logic   tx_buffer_empty_status_out,
  input wire logic   busy_out,
  input wire logic   irq_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_nss_low;
    (!nss_in && ctrl_out.master_enable_flag &&
     ctrl_out.select_mode_field == 2'h1) [*3];
  endsequence
  sequence s_disabled;
    flags_out.mode_fault_flag && !ctrl_out.master_enable_flag &&
    !ctrl_out.interface_enable_bit;
  endsequence

  a_fault_disables: assert property (
    s_nss_low |-> ##[0:2] s_disabled)
    else $error("Select low did not disable master");
  a_write_collides: assert property (
    busy_out && data_wr_in |-> ##[1:2] flags_out.write_collision_flag)
    else $error("Write during transfer not flagged");
  a_done_sticky: assert property (
    flags_out.transfer_done_flag && !flag_clr_in.transfer_done_flag
    |=> flags_out.transfer_done_flag)
    else $error("Done flag dropped without clear");
  a_done_at_end: assert property (
    $rose(flags_out.transfer_done_flag) |-> $fell(busy_out))
    else $error("Done flag not tied to transfer end");
  a_irq_follows: assert property (
    irq_out == $past(int_enable_in && (flags_out != 3'h0)))
    else $error("Interrupt request mismatch");
  a_tx_empty_drop: assert property (
    data_wr_in && !busy_out |=> !tx_buffer_empty_status_out)
    else $error("Buffer empty did not drop on write");
  a_start_moves: assert property (
    !tx_buffer_empty_status_out && !busy_out &&
    ctrl_out.master_enable_flag && ctrl_out.interface_enable_bit
    |=> tx_buffer_empty_status_out && busy_out)
    else $error("Buffered byte not moved to shifter");
  a_no_start_off: assert property (
    !ctrl_out.master_enable_flag && !busy_out |=> !busy_out)
    else $error("Transfer started while master disabled");
  a_select_drives: assert property (
    ctrl_out.select_mode_field[1] |=> !nss_oe_n_out &&
    nss_out == $past(ctrl_out.select_mode_field[0]))
    else $error("Select pin not driven from low select bit");
  a_three_wire_off: assert property (
    ctrl_out.select_mode_field == 2'h0 |=> nss_oe_n_out && nss_out)
    else $error("Select pin driven in three-wire mode");
endmodule

bind spi_master_ctrl spi_master_ctrl_props #(.HALF_CYCLES(HALF_CYCLES))
  props_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .flag_clr_in(flag_clr_in), .data_wr_in(data_wr_in),
  .int_enable_in(int_enable_in), .nss_in(nss_in), .nss_out(nss_out),
  .nss_oe_n_out(nss_oe_n_out), .ctrl_out(ctrl_out),
  .flags_out(flags_out),
  .tx_buffer_empty_status_out(tx_buffer_empty_status_out),
  .busy_out(busy_out), .irq_out(irq_out));

// [dv/spi_slave_model.sv]
`timescale 1ns/1ps
module spi_slave_model (
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       load_in,
  input  wire logic [7:0] byte_in,
  output logic            miso_out,
  output logic      [7:0] rx_out,
  output int              edges_out
);
  logic [7:0] shift;
  initial begin
    shift = 8'h00;
    rx_out = 8'h00;
    edges_out = 0;
  end
  assign miso_out = shift[7];
  always @(posedge load_in) begin
    shift = byte_in;
    edges_out = 0;
  end
  // Capture on rise, count clocks
  always @(posedge sck_in) begin
    rx_out <= {rx_out[6:0], mosi_in};
    edges_out <= edges_out + 1;
  end
  // Change after fall; spent bits toggle
  always @(negedge sck_in) begin
    shift <= {shift[6:0], ~shift[0]};
  end
endmodule

// [dv/spi_master_ctrl_tb.sv]
`timescale 1ns/1ps
module spi_master_ctrl_tb;
  import spi_master_pkg::*;
  logic        clk, rst, lclk, ctrl_wr, data_wr, int_en, miso, slave_select_pin;
  logic        sck, mosi, nss_o, nss_oe_n, tx_empty, busy, irq;
  logic        sl_load;
  logic  [7:0] data, rx_data, sl_byte, sl_rx;
  logic [15:0] exp;
  ctrl_s       ctrl, ctrl_o;
  flags_s      flag_clr, flags_o;
  int          sl_edges;
  int          fails = 0;
  int          n_checks = 0;
  int          seed = 11;
  int          cyc = 0;
  logic [15:0] notes[$];

  spi_master_ctrl spi_master_ctrl_inst (.ref_clk_in(clk),
    .sys_rst_in(rst), .link_clk_in(lclk), .ctrl_wr_in(ctrl_wr),
    .ctrl_in(ctrl), .flag_clr_in(flag_clr), .data_wr_in(data_wr),
    .data_in(data), .int_enable_in(int_en), .miso_in(miso),
    .nss_in(slave_select_pin), .sck_out(sck), .mosi_out(mosi), .nss_out(nss_o),
    .nss_oe_n_out(nss_oe_n), .ctrl_out(ctrl_o), .flags_out(flags_o),
    .tx_buffer_empty_status_out(tx_empty), .busy_out(busy),
    .rx_data_out(rx_data), .irq_out(irq));
  spi_slave_model spi_slave_model_inst (.sck_in(sck), .mosi_in(mosi),
    .load_in(sl_load), .byte_in(sl_byte), .miso_out(miso),
    .rx_out(sl_rx), .edges_out(sl_edges));

  always #50 clk = ~clk;
  initial begin
    lclk = 1'h0;
    #13;
    forever #32 lclk = ~lclk;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] e);
    n_checks++;
    if (seen !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_ctrl(logic [3:0] c);
    @(posedge clk);
    ctrl_wr <= 1'h1;
    ctrl <= ctrl_s'(c);
    @(posedge clk);
    ctrl_wr <= 1'h0;
  endtask
  task automatic clear(logic [2:0] f);
    @(posedge clk);
    flag_clr <= flags_s'(f);
    @(posedge clk);
    flag_clr <= flags_s'(3'h0);
    #1;
  endtask
  task automatic send(logic [7:0] m, logic [7:0] s);
    @(posedge clk);
    sl_byte <= s;
    sl_load <= 1'h1;
    @(posedge clk);
    sl_load <= 1'h0;
    data_wr <= 1'h1;
    data <= m;
    notes.push_back({s, m});
    @(posedge clk);
    data_wr <= 1'h0;
  endtask
  task automatic wait_busy();
    for (int i = 0; i < 20 && busy !== 1'h1; i++) tick(1);
  endtask
  task automatic finish_xfer();
    for (int i = 0; i < 300 && flags_o.transfer_done_flag !== 1'h1; i++)
      tick(1);
    tick(1);
    check("irq", 16'(irq), 16'(int_en));
    clear(3'h4);
  endtask

  always @(posedge flags_o.transfer_done_flag) begin
    #1;
    exp = notes.size() > 0 ? notes.pop_front() : 16'hFFFF;
    check("rx_data", 16'(rx_data), 16'(exp[15:8]));
    check("slave_rx", 16'(sl_rx), 16'(exp[7:0]));
    check("sck_count", 16'(sl_edges), 16'h0008);
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    {ctrl_wr, data_wr, sl_load, data, sl_byte} = '0;
    ctrl = ctrl_s'(4'h0);
    flag_clr = flags_s'(3'h0);
    int_en = 1'h1;
    slave_select_pin = 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    tick(1);
    check("reset", 16'({ctrl_o, flags_o, tx_empty}), 16'h0011);
    send(8'h81, 8'h3C);
    tick(20);
    check("held", 16'({busy, tx_empty}), 16'h0000);
    set_ctrl(4'hE);
    finish_xfer();
    check("nss_low", 16'({nss_oe_n, nss_o}), 16'h0000);
    set_ctrl(4'hF);
    tick(2);
    check("nss_high", 16'({nss_oe_n, nss_o}), 16'h0001);
    $display("test basic done");
    set_ctrl(4'hC);
    slave_select_pin <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      send(8'($random(seed)), 8'($random(seed)));
      finish_xfer();
    end
    check("three_wire", 16'({nss_oe_n, ctrl_o, flags_o}), 16'h00E0);
    slave_select_pin <= 1'h1;
    $display("test three wire done");
    send(8'h5A, 8'hC3);
    wait_busy();
    @(posedge clk);
    data_wr <= 1'h1;
    data <= 8'hFF;
    @(posedge clk);
    data_wr <= 1'h0;
    tick(2);
    check("collision", 16'(flags_o.write_collision_flag), 16'h1);
    finish_xfer();
    clear(3'h2);
    check("coll_clear", 16'(flags_o), 16'h0000);
    $display("test collision done");
    set_ctrl(4'hD);
    send(8'hE7, 8'h18);
    wait_busy();
    tick(3);
    slave_select_pin <= 1'h0;
    tick(12);
    check("fault", 16'({ctrl_o, flags_o, busy}), 16'h0012);
    check("fault_irq", 16'(irq), 16'h1);
    void'(notes.pop_back());
    slave_select_pin <= 1'h1;
    tick(20);
    check("stay_off", 16'({ctrl_o, flags_o, busy}), 16'h0012);
    clear(3'h1);
    set_ctrl(4'hF);
    int_en <= 1'h0;
    send(8'($random(seed)), 8'h96);
    finish_xfer();
    check("notes_left", 16'(notes.size()), 16'h0000);
    $display("test fault done");
    conclude();
  end
endmodule
